// File: inc/irq_route_pkg.sv
// constants and types shared by the interrupt enable and routing block
package irq_route_pkg;
  // printed offsets are not all multiples of four: they are register indices
  localparam logic [7:0] IDX_SOURCE_STATUS = 8'h0C;
  localparam logic [7:0] IDX_SOURCE_ENABLE = 8'h2D;
  localparam logic [7:0] IDX_PIN_ROUTING   = 8'h2E;
  localparam logic [7:0] IDX_PIN_CONFIG    = 8'h40;
  localparam logic [7:0] IDX_EVT_STATUS    = 8'h41;
  localparam logic [7:0] IDX_EVT_CLEAR     = 8'h42;
  localparam logic [7:0] IDX_EVT_ENABLE    = 8'h43;

  // source bit positions, shared by enable, routing and status
  localparam int BIT_SLEEP_WAKE = 7;
  localparam int BIT_TRANSIENT  = 5;
  localparam int BIT_ORIENT     = 4;
  localparam int BIT_PULSE      = 3;
  localparam int BIT_FALL_MOT   = 2;
  localparam int BIT_SAMPLE_RDY = 0;
  localparam logic [7:0] SOURCE_MASK = 8'hBD;

  // pin configuration fields
  localparam int BIT_POLARITY = 1;
  localparam int BIT_PAD_TYPE = 0;

  localparam logic [7:0] ENABLE_RESET  = 8'h00;
  localparam logic [7:0] ROUTING_RESET = 8'h00;
  localparam logic [1:0] CONFIG_RESET  = 2'h0;

  // block event bits: pin a rose, pin b rose
  localparam int EVT_PIN_A = 0;
  localparam int EVT_PIN_B = 1;

  typedef enum logic [1:0] {
    APB_IDLE   = 2'b00,
    APB_ACCESS = 2'b01
  } apb_state_t;

  typedef struct packed {
    apb_state_t  apb_state;
    logic [7:0]  enable;
    logic [7:0]  routing;
    logic [1:0]  pin_cfg;
    logic [1:0]  evt_status;
    logic [1:0]  evt_enable;
    logic        active_a;
    logic        active_b;
    logic        pin_a_out;
    logic        pin_a_oe;
    logic        pin_b_out;
    logic        pin_b_oe;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } state_t;
endpackage : irq_route_pkg

// File: rtl/accel_irq_enable_routing.sv
// interrupt enable, routing and pin driving stage with apb register access
// Notes on behaviour
// - a source reaches the pins only while its enable bit is set
// - all enable bits are zero after reset
// - enable bit 7 gates the sleep/wake source
// - enable bit 5 gates the transient source
// - enable bit 4 gates the orientation source
// - enable bit 3 gates the pulse source
// - enable bit 2 gates the fall/motion source
// - enable bit 0 gates sample ready; bits 6 and 1 read zero
// - routing bit per source picks the pin, same positions as enable
// - routing 0 sends the source to pin b, 1 to pin a
// - all routing bits are zero after reset, so pin b by default
// - several sources may hold one pin; it stays active while any does
// - only enabled sources reach pins; enable and routing are read/write
// - polarity 0 means active low pin, 1 means active high
// - pad type 0 is push-pull, 1 is open-drain
`timescale 1ns/10ps
module accel_irq_enable_routing
  import irq_route_pkg::*;
(
  input  wire logic        pclk,          // apb clock, 200 MHz
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb write
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  input  wire logic [3:0]  pstrb,         // apb byte strobes
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error, unmapped address
  input  wire logic [7:0]  source_events, // event levels from detectors
  output logic             irq_pin_a_out, // pin a output level
  output logic             irq_pin_a_oe,  // pin a output enable
  output logic             irq_pin_b_out, // pin b output level
  output logic             irq_pin_b_oe,  // pin b output enable
  output logic             irq            // block interrupt, active high
);

  // source and pin counts of this block
  localparam int NUM_SRC  = 8;
  localparam int NUM_PINS = 2;
  localparam int PIN_A    = 0;
  localparam int PIN_B    = 1;

  state_t                     st_reg;
  state_t                     st_next;

  // apb decode
  logic [7:0]                 idx;
  logic                       aligned;
  logic                       in_range;
  logic                       lo_byte;
  logic                       sel_status;
  logic                       sel_enable;
  logic                       sel_routing;
  logic                       sel_config;
  logic                       sel_evt_status;
  logic                       sel_evt_clear;
  logic                       sel_evt_enable;
  logic                       mapped;
  logic                       access;
  logic                       wr_hit;
  logic                       rd_hit;
  logic [31:0]                rd_data;

  // per-source controls
  logic                       sleep_wake_irq_enable;
  logic                       transient_irq_enable;
  logic                       orientation_irq_enable;
  logic                       pulse_irq_enable;
  logic                       fall_motion_irq_enable;
  logic                       sample_ready_irq_enable;
  logic                       sleep_wake_irq_route;
  logic                       transient_irq_route;
  logic                       orientation_irq_route;
  logic                       pulse_irq_route;
  logic                       fall_motion_irq_route;
  logic                       sample_ready_irq_route;
  logic [NUM_SRC-1:0]         enable_vec;
  logic [NUM_SRC-1:0]         route_vec;
  logic [NUM_SRC-1:0]         gated;

  // pin drive
  logic [NUM_SRC-1:0]         to_pin [NUM_PINS];
  logic [NUM_PINS-1:0]        pin_act;
  logic [NUM_PINS-1:0]        pin_lvl;
  logic [NUM_PINS-1:0]        pin_drv;
  logic [NUM_PINS-1:0]        pin_en;
  logic [NUM_PINS-1:0]        pin_was;
  logic                       polarity;
  logic                       open_drain;
  logic [1:0]                 evt_set;
  logic [1:0]                 evt_clr;

  // word index from the byte address; the two low bits must be zero
  assign idx      = paddr[9:2];
  assign aligned  = (paddr[1:0] == 2'h0);
  assign in_range = (paddr[11:10] == 2'h0);
  assign lo_byte  = pstrb[0];

  assign sel_status     = (idx == IDX_SOURCE_STATUS);
  assign sel_enable     = (idx == IDX_SOURCE_ENABLE);
  assign sel_routing    = (idx == IDX_PIN_ROUTING);
  assign sel_config     = (idx == IDX_PIN_CONFIG);
  assign sel_evt_status = (idx == IDX_EVT_STATUS);
  assign sel_evt_clear  = (idx == IDX_EVT_CLEAR);
  assign sel_evt_enable = (idx == IDX_EVT_ENABLE);

  // unaligned, out-of-range or unknown words are refused with pslverr
  assign mapped = aligned && in_range &&
                  (sel_status || sel_enable || sel_routing || sel_config ||
                   sel_evt_status || sel_evt_clear || sel_evt_enable);

  // the access phase is only taken once the setup cycle has been seen
  assign access = psel && penable && (st_reg.apb_state == APB_ACCESS);
  assign wr_hit = access && pwrite && mapped && lo_byte;
  assign rd_hit = access && !pwrite && mapped;

  // named views of the enable field
  assign sleep_wake_irq_enable   = st_reg.enable[BIT_SLEEP_WAKE];
  assign transient_irq_enable    = st_reg.enable[BIT_TRANSIENT];
  assign orientation_irq_enable  = st_reg.enable[BIT_ORIENT];
  assign pulse_irq_enable        = st_reg.enable[BIT_PULSE];
  assign fall_motion_irq_enable  = st_reg.enable[BIT_FALL_MOT];
  assign sample_ready_irq_enable = st_reg.enable[BIT_SAMPLE_RDY];

  // named views of the routing field, same positions as the enables
  assign sleep_wake_irq_route   = st_reg.routing[BIT_SLEEP_WAKE];
  assign transient_irq_route    = st_reg.routing[BIT_TRANSIENT];
  assign orientation_irq_route  = st_reg.routing[BIT_ORIENT];
  assign pulse_irq_route        = st_reg.routing[BIT_PULSE];
  assign fall_motion_irq_route  = st_reg.routing[BIT_FALL_MOT];
  assign sample_ready_irq_route = st_reg.routing[BIT_SAMPLE_RDY];

  // unused positions 6 and 1 stay zero in both vectors
  always_comb
  begin
    enable_vec                 = '0;
    enable_vec[BIT_SLEEP_WAKE] = sleep_wake_irq_enable;
    enable_vec[BIT_TRANSIENT]  = transient_irq_enable;
    enable_vec[BIT_ORIENT]     = orientation_irq_enable;
    enable_vec[BIT_PULSE]      = pulse_irq_enable;
    enable_vec[BIT_FALL_MOT]   = fall_motion_irq_enable;
    enable_vec[BIT_SAMPLE_RDY] = sample_ready_irq_enable;

    route_vec                  = '0;
    route_vec[BIT_SLEEP_WAKE]  = sleep_wake_irq_route;
    route_vec[BIT_TRANSIENT]   = transient_irq_route;
    route_vec[BIT_ORIENT]      = orientation_irq_route;
    route_vec[BIT_PULSE]       = pulse_irq_route;
    route_vec[BIT_FALL_MOT]    = fall_motion_irq_route;
    route_vec[BIT_SAMPLE_RDY]  = sample_ready_irq_route;
  end

  // one gate per source; a cleared enable keeps the event off both pins
  // detector levels on the unused positions never get through
  genvar s;
  generate
    for (s = 0; s < NUM_SRC; s++)
    begin : g_src
      assign gated[s] = source_events[s] & enable_vec[s];
    end
  endgenerate

  // routing 1 selects pin a, routing 0 pin b
  assign to_pin[PIN_A] = gated & route_vec;
  assign to_pin[PIN_B] = gated & ~route_vec;

  assign polarity   = st_reg.pin_cfg[BIT_POLARITY];
  assign open_drain = st_reg.pin_cfg[BIT_PAD_TYPE];

  // open-drain: the pad is pulled low when its level must be low and
  // released otherwise, so several pins can share one wired line; the
  // high level then comes from the line's pull-up
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++)
    begin : g_pin
      assign pin_act[p] = |to_pin[p];
      assign pin_lvl[p] = pin_act[p] ? polarity : ~polarity;
      assign pin_drv[p] = open_drain ? 1'b0 : pin_lvl[p];
      assign pin_en[p]  = open_drain ? ~pin_lvl[p] : 1'b1;
    end
  endgenerate

  // a pin event is the rising edge of its active state
  assign pin_was = {st_reg.active_b, st_reg.active_a};
  assign evt_set = pin_act & ~pin_was;
  assign evt_clr = (wr_hit && sel_evt_clear) ? pwdata[1:0] : 2'h0;

  // read data for the addressed word; write-only and unknown words read zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (idx)
      IDX_SOURCE_STATUS:
      begin
        rd_data = {24'h00_0000, gated};
      end
      IDX_SOURCE_ENABLE:
      begin
        rd_data = {24'h00_0000, st_reg.enable};
      end
      IDX_PIN_ROUTING:
      begin
        rd_data = {24'h00_0000, st_reg.routing};
      end
      IDX_PIN_CONFIG:
      begin
        rd_data = {30'h0, st_reg.pin_cfg};
      end
      IDX_EVT_STATUS:
      begin
        rd_data = {30'h0, st_reg.evt_status};
      end
      IDX_EVT_ENABLE:
      begin
        rd_data = {30'h0, st_reg.evt_enable};
      end
      default:
      begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // next state of every register of the block
  always_comb
  begin
    st_next           = st_reg;
    st_next.pready    = 1'b0;
    st_next.pslverr   = 1'b0;

    // pin drive registered so every pin output comes from a flip-flop
    st_next.active_a  = pin_act[PIN_A];
    st_next.active_b  = pin_act[PIN_B];
    st_next.pin_a_out = pin_drv[PIN_A];
    st_next.pin_a_oe  = pin_en[PIN_A];
    st_next.pin_b_out = pin_drv[PIN_B];
    st_next.pin_b_oe  = pin_en[PIN_B];

    // sticky pin events; a set in the same cycle as its clear wins
    st_next.evt_status = (st_reg.evt_status & ~evt_clr) | evt_set;

    // apb: setup moves to access, access answers and returns to idle
    case (st_reg.apb_state)
      APB_IDLE:
      begin
        if (psel && !penable)
        begin
          st_next.apb_state = APB_ACCESS;
        end
      end
      APB_ACCESS:
      begin
        // fixed single wait state: ready follows the first access edge
        st_next.apb_state = APB_IDLE;
        st_next.pready    = 1'b1;
        st_next.pslverr   = ~mapped;
        st_next.prdata    = 32'h0000_0000;
        if (rd_hit)
        begin
          st_next.prdata = rd_data;
        end
        // status and clear words take no write data here; clear acts above
        if (wr_hit && sel_enable)
        begin
          st_next.enable = pwdata[7:0] & SOURCE_MASK;
        end
        if (wr_hit && sel_routing)
        begin
          st_next.routing = pwdata[7:0] & SOURCE_MASK;
        end
        if (wr_hit && sel_config)
        begin
          st_next.pin_cfg = pwdata[1:0];
        end
        if (wr_hit && sel_evt_enable)
        begin
          st_next.evt_enable = pwdata[1:0];
        end
      end
      default:
      begin
        st_next.apb_state = APB_IDLE;
      end
    endcase

    // block interrupt follows the registered event state, not pin levels
    st_next.irq = |(st_next.evt_status & st_next.evt_enable);
  end

  // reset leaves the pins driven at the inactive high level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg            <= '0;
      st_reg.apb_state  <= APB_IDLE;
      st_reg.enable     <= ENABLE_RESET;
      st_reg.routing    <= ROUTING_RESET;
      st_reg.pin_cfg    <= CONFIG_RESET;
      st_reg.evt_status <= 2'h0;
      st_reg.evt_enable <= 2'h0;
      st_reg.active_a   <= 1'b0;
      st_reg.active_b   <= 1'b0;
      st_reg.irq        <= 1'b0;
      st_reg.prdata     <= 32'h0000_0000;
      st_reg.pready     <= 1'b0;
      st_reg.pslverr    <= 1'b0;
      st_reg.pin_a_out  <= 1'b1;
      st_reg.pin_b_out  <= 1'b1;
      st_reg.pin_a_oe   <= 1'b1;
      st_reg.pin_b_oe   <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign prdata        = st_reg.prdata;
  assign pready        = st_reg.pready;
  assign pslverr       = st_reg.pslverr;
  assign irq_pin_a_out = st_reg.pin_a_out;
  assign irq_pin_a_oe  = st_reg.pin_a_oe;
  assign irq_pin_b_out = st_reg.pin_b_out;
  assign irq_pin_b_oe  = st_reg.pin_b_oe;
  assign irq           = st_reg.irq;

endmodule : accel_irq_enable_routing

// File: test/irq_chk_checker.sv
// port assertions for the interrupt routing block
`timescale 1ns/10ps
module irq_chk (
  input logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input logic [11:0] paddr,
  input logic [31:0] pwdata, prdata,
  input logic [3:0]  pstrb,
  input logic [7:0]  source_events,
  input logic        irq_pin_a_out, irq_pin_a_oe, irq_pin_b_out, irq_pin_b_oe, irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_one_cycle:
    assert property (pready |=> !pready) else $error("pready held too long");
  chk_ready_after_access:
    assert property (pready |-> $past(psel && penable)) else $error("pready without access");
  chk_setup_no_ready:
    assert property (psel && !penable |-> !pready) else $error("pready in setup");
  chk_err_with_ready:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  chk_unaligned_err:
    assert property (pready && $past(paddr[1:0] != 2'h0) |-> pslverr)
      else $error("unaligned access accepted");
  chk_upper_zero:
    assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_err_reads_zero:
    assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not 0");
  chk_drain_low_only:
    assert property (!(irq_pin_a_out && !irq_pin_a_oe) && !(irq_pin_b_out && !irq_pin_b_oe))
      else $error("pin high while released");
  chk_pins_hold_quiet:
    assert property (($stable(source_events) && !(psel && pwrite))[*4] |->
      $stable({irq_pin_a_out, irq_pin_a_oe, irq_pin_b_out, irq_pin_b_oe}))
      else $error("pin moved without cause");
endmodule : irq_chk

bind accel_irq_enable_routing irq_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .pslverr, .paddr, .pwdata, .prdata, .pstrb, .source_events, .irq_pin_a_out,
  .irq_pin_a_oe, .irq_pin_b_out, .irq_pin_b_oe, .irq);

// File: test/irq_host.sv
// host side: resolves the interrupt wires and flags asserted pins
`timescale 1ns/10ps
module irq_host (
  input  logic a_out, a_oe, b_out, b_oe, pol,
  output logic a_hit, b_hit
);
  // released wire floats to the pull-up
  wire a_lvl = a_oe ? a_out : 1'b1;
  wire b_lvl = b_oe ? b_out : 1'b1;
  assign a_hit = a_lvl == pol;
  assign b_hit = b_lvl == pol;
endmodule : irq_host

// File: test/tb_top.sv
// self-checking bench for the interrupt routing block
`timescale 1ns/10ps
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin fails++; \
  $display("unexpected %0t %h %h", $time, g, x); end end
module tb_top
  import irq_route_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic pready, pslverr, a_o, a_e, b_o, b_e, irq, hit_a, hit_b;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [7:0]  se = 0, en, rt, ma, mb;
  logic [1:0]  cfg = 0;
  int fails = 0, checked = 0, cycles = 0;
  always #2.5 pclk = ~pclk;
  accel_irq_enable_routing DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .source_events(se), .irq_pin_a_out(a_o),
    .irq_pin_a_oe(a_e), .irq_pin_b_out(b_o), .irq_pin_b_oe(b_e), .irq);
  irq_host host (.a_out(a_o), .a_oe(a_e), .b_out(b_o), .b_oe(b_e), .pol(cfg[BIT_POLARITY]),
    .a_hit(hit_a), .b_hit(hit_b));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      fails++;
      stop_test;
    end
  end
  initial
  begin
    void'($urandom(32'h272E));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, {IDX_SOURCE_ENABLE, 2'h0}, 0);
    `CHK(r, 32'h0)
    apb(0, {IDX_PIN_ROUTING, 2'h0}, 0);
    `CHK(r, 32'h0)
    apb(0, 12'h0B5, 0);
    `CHK({e, r}, {1'b1, 32'h0})
    apb(0, 12'hFFC, 0);
    `CHK({e, r}, {1'b1, 32'h0})
    for (int k = 0; k < 40; k++)
    begin
      en = (k < 8) ? 8'h01 << k : 8'($urandom);
      rt = 8'($urandom);
      cfg = 2'(k);
      apb(1, {IDX_SOURCE_ENABLE, 2'h0}, {24'h0, en});
      apb(1, {IDX_PIN_ROUTING, 2'h0}, {24'h0, rt});
      apb(1, {IDX_PIN_CONFIG, 2'h0}, {30'h0, cfg});
      se <= (k < 8) ? 8'hFF : 8'($urandom);
      repeat (3) @(posedge pclk);
      ma = se & en & rt & SOURCE_MASK;
      mb = se & en & ~rt & SOURCE_MASK;
      `CHK({hit_a, hit_b}, {|ma, |mb})
      apb(0, {IDX_SOURCE_ENABLE, 2'h0}, 0);
      `CHK(r, {24'h0, en & SOURCE_MASK})
      apb(0, {IDX_PIN_ROUTING, 2'h0}, 0);
      `CHK(r, {24'h0, rt & SOURCE_MASK})
      apb(0, {IDX_PIN_CONFIG, 2'h0}, 0);
      `CHK(r, {30'h0, cfg})
      apb(0, {IDX_SOURCE_STATUS, 2'h0}, 0);
      `CHK(r, {24'h0, ma | mb})
    end
    se <= 8'h00;
    cfg = 2'h0;
    apb(1, {IDX_PIN_CONFIG, 2'h0}, 0);
    apb(1, {IDX_PIN_ROUTING, 2'h0}, 32'h000000FF);
    apb(1, {IDX_SOURCE_ENABLE, 2'h0}, 32'h000000BD);
    apb(1, {IDX_EVT_CLEAR, 2'h0}, 32'h00000003);
    apb(1, {IDX_EVT_ENABLE, 2'h0}, 32'h00000003);
    se <= 8'h01;
    repeat (4) @(posedge pclk);
    `CHK(irq, 1'b1)
    apb(0, {IDX_EVT_STATUS, 2'h0}, 0);
    `CHK(r, 32'h1)
    apb(1, {IDX_EVT_ENABLE, 2'h0}, 32'h00000002);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1, {IDX_EVT_ENABLE, 2'h0}, 32'h00000003);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b1)
    apb(1, {IDX_EVT_CLEAR, 2'h0}, 32'h00000001);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1, {IDX_EVT_ENABLE, 2'h0}, 32'h00000003);
    se <= 8'h00;
    repeat (2) @(posedge pclk);
    se <= 8'h01;
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b1)
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    `CHK({irq, a_o, a_e, b_o, b_e}, 5'b01111)
    apb(0, {IDX_SOURCE_ENABLE, 2'h0}, 0);
    `CHK(r, 32'h0)
    apb(0, {IDX_PIN_ROUTING, 2'h0}, 0);
    `CHK(r, 32'h0)
    stop_test;
  end
endmodule : tb_top
